// ### src/hdaf_rx_filter.sv
// Purpose: hdlc receive address filter with apb registers and buffer
// Assumes: line clock and data arrive on pins, asynchronous to pclk
// Notes: one wait state on every apb transfer
// Overview of operation
// - five receive modes from mode register
// - auto mode: 1/2-byte address, mod 8/128
// - high byte versus group and two sapi values
// - bit 1 is c/r, masked from compare
// - low byte versus group and two tei values
// - valid address only for seven pairings
// - only sapi1/terminal_id_compare_1 connection runs autonomously
// - unmatched frames are ignored entirely
// - 1-byte address: terminal_id_compare_1 command, terminal_id_compare_2 response
// - auto: control to register, info to buffer
// - non-auto: same addressing, any window size
// - mode 101: tei check on second byte
// - mode 110: store every byte through crc
// - mode 111: sapi check on first byte
// - flags, destuffing and crc checked on receive
// - 64-byte receive buffer toward the host
// - 2-byte address only when low bit set
// - group tei compared only for 2-byte address
// - mod-128 i-frame control stored compressed
// - extended control: s/u-frame second byte into buffer, i-frame second byte folded into control register
`timescale 1ns/100ps
module hdaf_rx_filter
  import hdaf_pkg::*;
#(
  parameter int BUF_DEPTH = 64,
  parameter int PADDR_W = 12
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial receive pins
  input wire logic rx_bit_clk,
  input wire logic rx_data
);
  localparam int PW = $clog2(BUF_DEPTH);
  localparam logic [PW:0] P_ONE = (PW+1)'(1);
  localparam logic [PW:0] P_TWO = (PW+1)'(2);
  localparam logic [PW:0] P_DEPTH = (PW+1)'(BUF_DEPTH);

  typedef struct packed {
    logic ck1;
    logic ck2;
    logic ck3;
    logic dt1;
    logic dt2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] mode;
    logic [7:0] sapi_compare_1;
    logic [7:0] sapi_compare_2;
    logic [7:0] terminal_id_compare_1;
    logic [7:0] terminal_id_compare_2;
    logic [7:0] receive_control_field_reg;
    logic [7:0] received_first_address_byte_reg;
    logic [7:0] receive_frame_status;
    logic [7:0] rbcl;
    logic done;
    logic aconn;
    logic [2:0] idx;
    logic acc;
    logic [7:0] p_hi;
    logic [7:0] p_receive_control_field_reg;
    logic [1:0] p_sa;
    logic p_cr;
    logic p_ta;
    logic p_ac;
    logic p_rdo;
    logic [PW:0] wr;
    logic [PW:0] sp;
    logic [PW:0] rd;
  } hdaf_state_t;

  hdaf_state_t s_ff;
  hdaf_state_t nxt_s;
  hdaf_rx_ev_t ev;
  logic [7:0] mem [BUF_DEPTH];
  logic buf_we;
  logic [7:0] buf_wd;

  ////////////////////////////////////////////////////////////////////////
  // deframer
  hdaf_hdlc_deframer u_dfr (
    .pclk(pclk),
    .presetn(presetn),
    .bit_stb(s_ff.ck2 & ~s_ff.ck3),
    .bit_in(s_ff.dt2),
    .ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // buffer storage
  always_ff @(posedge pclk) begin
    if (buf_we) begin
      mem[s_ff.sp[PW-1:0]] <= buf_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0] m;
    logic two;
    logic au;
    logic extended_control_select;
    logic [7:0] b;
    logic [7:0] hb;
    logic h1;
    logic h2;
    logic hg;
    logic t1;
    logic t2;
    logic tg;
    logic pair;
    logic [1:0] sa;
    logic tobuf;
    logic [2:0] ctl;
    logic [PW:0] trim;
    logic [PW:0] newwr;
    logic [7:0] ai;
    logic hit;
    logic xfer;
    logic nempty;
    m = '0;
    two = 1'b0;
    au = 1'b0;
    extended_control_select = 1'b0;
    b = '0;
    hb = '0;
    h1 = 1'b0;
    h2 = 1'b0;
    hg = 1'b0;
    t1 = 1'b0;
    t2 = 1'b0;
    tg = 1'b0;
    pair = 1'b0;
    sa = '0;
    tobuf = 1'b0;
    ctl = '0;
    trim = '0;
    newwr = '0;
    ai = '0;
    hit = 1'b0;
    xfer = 1'b0;
    nempty = 1'b0;
    nxt_s = s_ff;
    buf_we = 1'b0;
    buf_wd = ev.data;

    // pin synchronisers
    nxt_s.ck1 = rx_bit_clk;
    nxt_s.ck2 = s_ff.ck1;
    nxt_s.ck3 = s_ff.ck2;
    nxt_s.dt1 = rx_data;
    nxt_s.dt2 = s_ff.dt1;

    // mode decode
    m = s_ff.mode[MODE_LSB+2:MODE_LSB];
    two = m[0];
    au = (m[2:1] == MD_AUTO);
    extended_control_select = s_ff.sapi_compare_2[MCS_BIT];
    b = ev.data;
    hb = (s_ff.idx == 3'd0) ? b : s_ff.p_hi;
    h1 = (hb & SAPI_MASK) == (s_ff.sapi_compare_1 & SAPI_MASK);
    h2 = (hb & SAPI_MASK) == (s_ff.sapi_compare_2 & SAPI_MASK);
    hg = (hb & SAPI_MASK) == GRP_SAPI;
    t1 = (b == s_ff.terminal_id_compare_1);
    t2 = (b == s_ff.terminal_id_compare_2);
    tg = (b == GRP_TEI);
    pair = (h1 & (t1 | tg)) | (h2 & (t2 | tg)) | (hg & (t1 | t2 | tg));
    sa = h1 ? 2'b00 : (h2 ? 2'b01 : 2'b10);
    ctl = two ? 3'd2 : 3'd1;

    ////////////////////////////////////////////////////////////////////
    // per received byte
    if (ev.byte_stb) begin
      if (s_ff.idx != 3'd7) begin
        nxt_s.idx = s_ff.idx + 3'd1;
      end
      if (!m[2]) begin
        // auto and non-auto share address handling
        if (two && s_ff.idx == 3'd0) begin
          nxt_s.p_hi = b;
        end else if (s_ff.idx == (two ? 3'd1 : 3'd0)) begin
          if (two) begin
            nxt_s.acc = pair;
            nxt_s.p_sa = sa;
            nxt_s.p_cr = s_ff.p_hi[1] ^ s_ff.sapi_compare_1[CRI_BIT];
            nxt_s.p_ta = t1 | t2;
            nxt_s.p_ac = au & h1 & t1;
          end else begin
            // group tei is not a match here
            nxt_s.acc = t1 | t2;
            nxt_s.p_cr = t2;
            nxt_s.p_ta = 1'b1;
            nxt_s.p_ac = au & t1;
          end
        end else if (s_ff.idx == ctl) begin
          nxt_s.p_receive_control_field_reg = b;
        end else if (s_ff.idx == ctl + 3'd1 && au && extended_control_select && !s_ff.p_receive_control_field_reg[0]) begin
          // i-frame: n(r) low bits, p, n(s) low bits
          nxt_s.p_receive_control_field_reg = {b[3:1], b[0], s_ff.p_receive_control_field_reg[3:1], 1'b0};
        end else begin
          tobuf = 1'b1;
        end
      end else if (m == MD_TR2) begin
        nxt_s.acc = 1'b1;
        tobuf = 1'b1;
      end else if (m == MD_TR3) begin
        if (s_ff.idx == 3'd0) begin
          nxt_s.acc = h1 | h2 | hg;
          nxt_s.p_sa = sa;
          nxt_s.p_cr = b[1] ^ s_ff.sapi_compare_1[CRI_BIT];
        end else begin
          tobuf = 1'b1;
        end
      end else begin
        if (s_ff.idx == 3'd0) begin
          nxt_s.p_hi = b;
        end else if (s_ff.idx == 3'd1) begin
          nxt_s.acc = t1 | t2 | tg;
          nxt_s.p_ta = t1 | t2;
        end else if (s_ff.idx == 3'd2) begin
          nxt_s.p_receive_control_field_reg = b;
        end else begin
          tobuf = 1'b1;
        end
      end
      // only frames accepted by this byte or an earlier one reach the buffer
      if (tobuf && nxt_s.acc) begin
        if ((s_ff.sp - s_ff.rd) == P_DEPTH) begin
          nxt_s.p_rdo = 1'b1;
        end else begin
          buf_we = 1'b1;
          nxt_s.sp = s_ff.sp + P_ONE;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////
    // frame end: commit or discard
    if (ev.frame_end) begin
      trim = (m == MD_TR2) ? '0 : P_TWO;
      newwr = ((s_ff.sp - s_ff.wr) >= trim) ? (s_ff.sp - trim) : s_ff.wr;
      if (s_ff.acc && !ev.abort) begin
        nxt_s.wr = newwr;
        nxt_s.sp = newwr;
        nxt_s.rbcl = 8'(newwr - s_ff.wr);
        nxt_s.receive_control_field_reg = s_ff.p_receive_control_field_reg;
        nxt_s.received_first_address_byte_reg = s_ff.p_hi;
        nxt_s.aconn = s_ff.p_ac;
        nxt_s.done = 1'b1;
      end else begin
        nxt_s.sp = s_ff.wr;
      end
      if (s_ff.acc) begin
        nxt_s.receive_frame_status = {1'b0, s_ff.p_rdo, ev.crc_ok, ev.abort,
                      s_ff.p_sa, s_ff.p_cr, s_ff.p_ta};
      end
      nxt_s.idx = '0;
      nxt_s.acc = 1'b0;
      nxt_s.p_rdo = 1'b0;
      nxt_s.p_ac = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave
    ai = paddr[9:2];
    hit = (paddr[PADDR_W-1:10] == '0) &&
          (ai == IDX_MODE || ai == IDX_RBCL || ai == IDX_RECEIVED_FIRST_ADDRESS_BYTE_REG ||
           ai == IDX_RECEIVE_FRAME_STATUS || ai == IDX_RECEIVE_CONTROL_FIELD_REG || ai == IDX_SAPI_COMPARE_1 ||
           ai == IDX_SAPI_COMPARE_2 || ai == IDX_TERMINAL_ID_COMPARE_1 || ai == IDX_TERMINAL_ID_COMPARE_2 ||
           ai == IDX_RDAT || ai == IDX_CMD);
    nempty = (s_ff.wr != s_ff.rd);
    nxt_s.pready = psel & ~penable;
    nxt_s.pslverr = psel & ~penable & ~hit;
    if (psel && !penable) begin
      nxt_s.prdata = '0;
      if (!pwrite && hit) begin
        case (ai)
          IDX_MODE: nxt_s.prdata[7:0] = s_ff.mode;
          IDX_RBCL: nxt_s.prdata[7:0] = s_ff.rbcl;
          IDX_RECEIVED_FIRST_ADDRESS_BYTE_REG: nxt_s.prdata[7:0] = s_ff.received_first_address_byte_reg;
          IDX_RECEIVE_FRAME_STATUS: nxt_s.prdata[7:0] = {nempty, s_ff.receive_frame_status[6:0]};
          IDX_RECEIVE_CONTROL_FIELD_REG: nxt_s.prdata[7:0] = s_ff.receive_control_field_reg;
          IDX_SAPI_COMPARE_1: nxt_s.prdata[7:0] = s_ff.sapi_compare_1;
          IDX_SAPI_COMPARE_2: nxt_s.prdata[7:0] = s_ff.sapi_compare_2;
          IDX_TERMINAL_ID_COMPARE_1: nxt_s.prdata[7:0] = s_ff.terminal_id_compare_1;
          IDX_TERMINAL_ID_COMPARE_2: nxt_s.prdata[7:0] = s_ff.terminal_id_compare_2;
          IDX_RDAT: nxt_s.prdata[7:0] = nempty ? mem[s_ff.rd[PW-1:0]] : 8'h00;
          IDX_CMD: nxt_s.prdata[1:0] = {s_ff.aconn, s_ff.done};
          default: nxt_s.prdata = '0;
        endcase
      end
    end
    xfer = psel & penable & s_ff.pready & hit;
    if (xfer && !pwrite && ai == IDX_RDAT && nempty) begin
      nxt_s.rd = s_ff.rd + P_ONE;
    end
    if (xfer && pwrite && pstrb[0]) begin
      case (ai)
        IDX_MODE: nxt_s.mode = pwdata[7:0];
        IDX_SAPI_COMPARE_1: nxt_s.sapi_compare_1 = pwdata[7:0];
        IDX_SAPI_COMPARE_2: nxt_s.sapi_compare_2 = pwdata[7:0];
        IDX_TERMINAL_ID_COMPARE_1: nxt_s.terminal_id_compare_1 = pwdata[7:0];
        IDX_TERMINAL_ID_COMPARE_2: nxt_s.terminal_id_compare_2 = pwdata[7:0];
        IDX_CMD: begin
          // a frame committed in this cycle keeps done set
          if (pwdata[RMC_BIT] && !(ev.frame_end && s_ff.acc && !ev.abort)) begin
            nxt_s.done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.mode <= RST_REG;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
endmodule

// ### src/hdaf_pkg.sv
// Purpose: shared constants and carriers for the hdlc receive filter
// Assumes: 32-bit apb, registers at byte address four times the index
// Notes: indices are kept as printed, the bus address is index*4
package hdaf_pkg;
  // register indices
  localparam logic [7:0] IDX_MODE = 8'h22;
  localparam logic [7:0] IDX_RBCL = 8'h25;
  localparam logic [7:0] IDX_RECEIVED_FIRST_ADDRESS_BYTE_REG = 8'h26;
  localparam logic [7:0] IDX_RECEIVE_FRAME_STATUS = 8'h27;
  localparam logic [7:0] IDX_RECEIVE_CONTROL_FIELD_REG = 8'h29;
  localparam logic [7:0] IDX_SAPI_COMPARE_1 = 8'h30;
  localparam logic [7:0] IDX_SAPI_COMPARE_2 = 8'h31;
  localparam logic [7:0] IDX_TERMINAL_ID_COMPARE_1 = 8'h32;
  localparam logic [7:0] IDX_TERMINAL_ID_COMPARE_2 = 8'h33;
  localparam logic [7:0] IDX_RDAT = 8'h34;
  localparam logic [7:0] IDX_CMD = 8'h35;
  // field positions
  localparam int MODE_LSB = 5;
  localparam int CRI_BIT = 1;
  localparam int MCS_BIT = 1;
  localparam int RMC_BIT = 0;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // transfer mode codes
  localparam logic [1:0] MD_AUTO = 2'b00;
  localparam logic [2:0] MD_TR2 = 3'b110;
  localparam logic [2:0] MD_TR3 = 3'b111;
  // fixed address values
  localparam logic [7:0] GRP_SAPI = 8'hFC;
  localparam logic [7:0] SAPI_MASK = 8'hFD;
  localparam logic [7:0] GRP_TEI = 8'hFF;
  // crc and flag figures
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [2:0] ONES_STUFF = 3'd5;
  localparam logic [2:0] ONES_FLAG = 3'd6;
  localparam logic [2:0] ONES_ABORT = 3'd7;
  localparam logic [2:0] BITS_ALIGNED = 3'd6;
  // receive events from the deframer
  typedef struct packed {
    logic byte_stb;
    logic [7:0] data;
    logic frame_end;
    logic crc_ok;
    logic abort;
  } hdaf_rx_ev_t;
endpackage

// ### src/hdaf_hdlc_deframer.sv
// Purpose: flag hunt, zero destuffing, byte assembly and crc check
// Assumes: one bit_stb per received line bit, lsb first
// Notes: crc covers every emitted byte including the fcs
`timescale 1ns/100ps
module hdaf_hdlc_deframer
  import hdaf_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial bits
  input wire logic bit_stb,
  input wire logic bit_in,
  // events
  output hdaf_rx_ev_t ev
);
  typedef struct packed {
    logic [2:0] ones;
    logic in_fr;
    logic got;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic [15:0] crc;
    hdaf_rx_ev_t ev;
  } hdaf_dfr_t;

  hdaf_dfr_t s_ff;
  hdaf_dfr_t nxt_s;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    logic push;
    push = 1'b0;
    nxt_s = s_ff;
    nxt_s.ev = '0;
    if (bit_stb) begin
      if (bit_in) begin
        if (s_ff.ones != ONES_ABORT) begin
          nxt_s.ones = s_ff.ones + 3'd1;
        end
        if (s_ff.ones == ONES_FLAG) begin
          // seventh one in a row ends the frame as aborted
          nxt_s.ev.frame_end = s_ff.in_fr & s_ff.got;
          nxt_s.ev.abort = s_ff.in_fr & s_ff.got;
          nxt_s.in_fr = 1'b0;
          nxt_s.got = 1'b0;
        end else if (s_ff.ones < ONES_STUFF) begin
          push = 1'b1;
        end
      end else begin
        nxt_s.ones = 3'd0;
        if (s_ff.ones == ONES_FLAG) begin
          // flag closes a frame and opens the next
          nxt_s.ev.frame_end = s_ff.in_fr & s_ff.got;
          nxt_s.ev.crc_ok = (s_ff.crc == CRC_GOOD) && (s_ff.bcnt == BITS_ALIGNED);
          nxt_s.in_fr = 1'b1;
          nxt_s.got = 1'b0;
          nxt_s.bcnt = 3'd0;
          nxt_s.crc = CRC_INIT;
        end else if (s_ff.ones != ONES_STUFF) begin
          push = 1'b1; // stuffed zero after five ones is dropped
        end
      end
    end
    if (push) begin
      nxt_s.sh = {bit_in, s_ff.sh[7:1]};
      nxt_s.bcnt = s_ff.bcnt + 3'd1;
      if (s_ff.in_fr && s_ff.bcnt == 3'd7) begin
        nxt_s.ev.byte_stb = 1'b1;
        nxt_s.ev.data = {bit_in, s_ff.sh[7:1]};
        nxt_s.crc = crc_byte(s_ff.crc, {bit_in, s_ff.sh[7:1]});
        nxt_s.got = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign ev = s_ff.ev;
endmodule

// ### bench/hdaf_rx_filter_checker.sv
// Purpose: bus-side assertions for the receive filter
// Assumes: one wait state, register index in paddr[9:2]
// Notes: bound to the filter from the bench top
`timescale 1ns/100ps
module hdaf_rx_filter_checker
  import hdaf_pkg::*;
#(
  parameter int PADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [7:0] tei_cmp_ff;
  logic setup;
  logic bad;
  logic [7:0] reg_idx;
  assign setup = psel && !penable;
  assign reg_idx = paddr[9:2];
  // refused: upper address bits set or no register at this index
  assign bad = (paddr[PADDR_W-1:10] != '0) ||
               !(reg_idx inside {IDX_MODE, IDX_RBCL, IDX_RECEIVED_FIRST_ADDRESS_BYTE_REG, IDX_RECEIVE_FRAME_STATUS, IDX_RECEIVE_CONTROL_FIELD_REG, IDX_SAPI_COMPARE_1,
                 IDX_SAPI_COMPARE_2, IDX_TERMINAL_ID_COMPARE_1, IDX_TERMINAL_ID_COMPARE_2, IDX_RDAT, IDX_CMD});
  ////////////////////////////////////////////////////////////
  // shadow of the terminal compare register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tei_cmp_ff <= RST_REG;
    end else if (pready && pwrite && pstrb[0] && !bad && paddr[9:2] == IDX_TERMINAL_ID_COMPARE_1) begin
      tei_cmp_ff <= pwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_wait_a: assert property (setup |=> pready && penable)
    else $error("ready missing after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  bad_read_a: assert property (setup && !pwrite && bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  mode_ok_a: assert property (setup && !bad && paddr[9:2] == IDX_MODE |=> !pslverr)
    else $error("mode access refused");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  read_hold_a: assert property (!setup |=> $stable(prdata))
    else $error("read data moved outside setup");
  tei_back_a: assert property (setup && !pwrite && !bad && paddr[9:2] == IDX_TERMINAL_ID_COMPARE_1 |=>
    prdata[7:0] == tei_cmp_ff)
    else $error("terminal compare readback wrong");
  cover property (pslverr);
  cover property (setup && !pwrite ##1 pready);
  cover property (setup && pwrite ##1 pready);
endmodule

// ### bench/hdaf_line_model.sv
// Purpose: remote station sending hdlc frames on the line pins
// Assumes: bit clock of 8 pclk, data set 3 pclk before rise
// Notes: bit clock stands low between frames
`timescale 1ns/100ps
module hdaf_line_model (
  // clock
  input wire logic pclk,
  // line pins
  output logic rx_bit_clk,
  output logic rx_data
);
  initial begin
    rx_bit_clk = 1'b0;
    rx_data = 1'b1;
  end
  task automatic put(input logic b);
    @(posedge pclk) rx_data <= b;
    repeat (3) @(posedge pclk);
    rx_bit_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    rx_bit_clk <= 1'b0;
  endtask
  // one frame at a time, never more than one outstanding
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] crc;
    logic fb;
    int ones;
    crc = 16'hFFFF;
    ones = 0;
    foreach (q[k]) for (int i = 0; i < 8; i++) begin
      fb = crc[0] ^ q[k][i];
      crc = crc >> 1;
      if (fb) crc = crc ^ 16'h8408;
    end
    q.push_back(~crc[7:0]);
    q.push_back(~crc[15:8]);
    for (int i = 0; i < 8; i++) put(i != 0 && i != 7);
    foreach (q[k]) for (int i = 0; i < 8; i++) begin
      put(q[k][i]);
      ones = q[k][i] ? ones + 1 : 0;
      if (ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
    for (int i = 0; i < 8; i++) put(i != 0 && i != 7);
    // released line shows no stale level
    rx_data <= ~rx_data;
  endtask
endmodule

// ### bench/hdlc_rx_address_filter_tb_top.sv
// Purpose: self-checking bench for the receive address filter
// Assumes: apb with one wait state, frames from the line model
// Notes: each frame check clears frame_done first
`timescale 1ns/100ps
module hdlc_rx_address_filter_tb_top
  import hdaf_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_bit_clk, rx_data;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic rerr, cr0;
  int n_fail, n_checks;
  hdaf_rx_filter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_bit_clk(rx_bit_clk), .rx_data(rx_data));
  hdaf_line_model line (.pclk(pclk), .rx_bit_clk(rx_bit_clk), .rx_data(rx_data));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0000_00, d};
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until ready is seen at a rising edge; the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 8'h00);
    chk(nm, e, rdv);
  endtask
  // send one frame, then check done flag, first buffer byte, control field
  task frm(input logic [7:0] q[$], input logic acc, input logic [8:0] ctl, input logic [7:0] d0);
    apb(1'b1, IDX_CMD, 8'h01);
    line.send(q);
    repeat (20) @(posedge pclk);
    apb(1'b0, IDX_CMD, 8'h00);
    chk("done", {31'h0, acc}, {31'h0, rdv[0]});
    rdc("data", IDX_RDAT, acc ? {24'h0, d0} : 32'h0);
    if (!ctl[8]) rdc("ctrl", IDX_RECEIVE_CONTROL_FIELD_REG, {24'h0, ctl[7:0]});
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    rdc("mode", IDX_MODE, 32'h0);
    rdc("terminal_id_compare_1", IDX_TERMINAL_ID_COMPARE_1, 32'h0);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 32'h1, {31'h0, rerr});
    apb(1'b1, IDX_SAPI_COMPARE_1, 8'h10);
    apb(1'b1, IDX_SAPI_COMPARE_2, 8'h20);
    apb(1'b1, IDX_TERMINAL_ID_COMPARE_1, 8'h03);
    apb(1'b1, IDX_TERMINAL_ID_COMPARE_2, 8'h05);
  endtask
  task t_pairs;
    logic [7:0] hi[9] = '{8'h10, 8'h10, 8'h20, 8'h20, 8'hFC, 8'hFE, 8'hFE, 8'h20, 8'h10};
    logic [7:0] lo[9] = '{8'h03, 8'hFF, 8'h05, 8'hFF, 8'h03, 8'h05, 8'hFF, 8'h03, 8'h05};
    logic [8:0] last;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, IDX_MODE, m ? 8'h60 : 8'h20);
      for (int i = 0; i < 9; i++) begin
        if (i < 7) last = {1'b0, 4'(i), 4'h3};
        frm({hi[i], lo[i], 8'({4'(i), 4'h3}), 8'h50 + 8'(i)}, i < 7, last, 8'h50 + 8'(i));
        if (i == 0) rdc("conn", IDX_CMD, m ? 32'h1 : 32'h3);
      end
    end
    rdc("count", IDX_RBCL, 32'h1);
    frm({8'h12, 8'h03, 8'h03, 8'h5A}, 1'b1, 9'h003, 8'h5A);
  endtask
  task t_ext;
    apb(1'b1, IDX_MODE, 8'h20);
    apb(1'b1, IDX_SAPI_COMPARE_2, 8'h22);
    frm({8'h10, 8'h03, 8'h04, 8'h0B, 8'h99}, 1'b1, 9'h0B4, 8'h99);
    frm({8'h10, 8'h03, 8'h01, 8'h0B}, 1'b1, 9'h001, 8'h0B);
    apb(1'b1, IDX_SAPI_COMPARE_2, 8'h20);
  endtask
  task t_one_byte;
    apb(1'b1, IDX_MODE, 8'h00);
    frm({8'h03, 8'h13, 8'h88}, 1'b1, 9'h013, 8'h88);
    apb(1'b0, IDX_RECEIVE_FRAME_STATUS, 8'h00);
    cr0 = rdv[1];
    chk("crc", 32'h1, {31'h0, rdv[5]});
    frm({8'h05, 8'h23, 8'h77}, 1'b1, 9'h023, 8'h77);
    apb(1'b0, IDX_RECEIVE_FRAME_STATUS, 8'h00);
    chk("cr", {31'h0, ~cr0}, {31'h0, rdv[1]});
    frm({8'hFF, 8'h33, 8'h66}, 1'b0, 9'h023, 8'h00);
  endtask
  task t_trans;
    apb(1'b1, IDX_MODE, 8'hA0);
    frm({8'h77, 8'h05, 8'h13, 8'h44}, 1'b1, 9'h013, 8'h44);
    rdc("first", IDX_RECEIVED_FIRST_ADDRESS_BYTE_REG, 32'h77);
    apb(1'b1, IDX_MODE, 8'hE0);
    frm({8'h22, 8'h31}, 1'b1, 9'h100, 8'h31);
    frm({8'h40, 8'h32}, 1'b0, 9'h100, 8'h00);
    apb(1'b1, IDX_MODE, 8'hC0);
    frm({8'h01, 8'h02}, 1'b1, 9'h100, 8'h01);
    rdc("count", IDX_RBCL, 32'h4);
    rdc("second", IDX_RDAT, 32'h02);
    apb(1'b0, IDX_RDAT, 8'h00);
    apb(1'b0, IDX_RDAT, 8'h00);
    apb(1'b0, IDX_RECEIVE_FRAME_STATUS, 8'h00);
    chk("empty", 32'h0, {31'h0, rdv[7]});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pairs();
    t_ext();
    t_one_byte();
    t_trans();
    test_done();
  end
  initial begin
    repeat (50000) @(posedge pclk);
    n_fail++;
    test_done();
  end
endmodule
bind hdaf_rx_filter hdaf_rx_filter_checker #(.PADDR_W(PADDR_W)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
